// [design/clk_ctrl_pkg.sv]
// Purpose: Shared constants and types for the clock generator control block
// Assumes: 250 MHz system clock, byte-wide registers on a 32-bit Wishbone bus
// Notes: Register offsets are byte addresses of aligned words
package clk_ctrl_pkg;

   // Register byte offsets
   localparam logic [7:0] OFF_PROC = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_MOSC = 8'h08;
   localparam logic [7:0] OFF_IOSC = 8'h0c;
   localparam logic [7:0] OFF_PIN = 8'h10;
   localparam logic [7:0] OFF_WAKE = 8'h14;

   // processor_clock_ctrl fields
   localparam int PROC_DIV_LSB = 0;
   localparam int PROC_CPU_SRC = 4;
   localparam int PROC_SUB_ACT = 5;
   localparam int PROC_SUB_FORCE = 6;
   // main_clock_mode fields
   localparam int MODE_MAIN_SRC = 0;
   localparam int MODE_MAIN_STS = 1;
   localparam int MODE_HS_SRC = 2;
   // main_osc_ctrl fields
   localparam int MOSC_STOP = 7;
   // internal_osc_ctrl fields
   localparam int IOSC_STOP = 0;
   localparam int IOSC_STABLE = 1;
   // osc_pin_mode_ctrl fields
   localparam int PIN_SUB_SEL = 4;
   localparam int PIN_SUB_EXT = 5;
   localparam int PIN_MAIN_SEL = 6;
   localparam int PIN_MAIN_EXT = 7;
   // wake stabilisation select field
   localparam int WAKE_LSB = 0;

   // Values after reset, and the highest legal divider code
   localparam logic [2:0] RST_CPU_DIV = 3'h1;
   localparam logic RST_MAIN_OSC_STOP = 1'b1;
   localparam logic [2:0] RST_WAKE_SEL = 3'h0;
   localparam logic [2:0] DIV_MAX_CODE = 3'h4;

   // Timing
   localparam int CLK_MHZ = 250;
   localparam int INT_STAB_NS = 2000;
   localparam int INT_STAB_CYCLES = (INT_STAB_NS * CLK_MHZ + 999) / 1000;
   localparam int SWITCH_NS = 16;
   localparam int SWITCH_CYCLES = (SWITCH_NS * CLK_MHZ + 999) / 1000;

   typedef enum logic [1:0] {
      PIN_PORT = 2'b00,
      PIN_OSC = 2'b01,
      PIN_EXT = 2'b10
   } pin_mode_t;

   typedef enum logic {
      PWR_RUN = 1'b0,
      PWR_STOP = 1'b1
   } pwr_state_t;

   // Pin pair mode from force, external select and enable bits
   function automatic pin_mode_t pin_mode(input logic force_osc, input logic ext,
                                          input logic sel);
      if (force_osc) begin
         pin_mode = PIN_OSC;
      end else if (!sel) begin
         pin_mode = PIN_PORT;
      end else if (ext) begin
         pin_mode = PIN_EXT;
      end else begin
         pin_mode = PIN_OSC;
      end
   endfunction

endpackage

// [design/osc_stab_timer.sv]
// Purpose: Counts the accuracy settling time of a restarted oscillator
// Assumes: run_i low while the oscillator is halted
// Notes: stable_o drops on the first clock edge that samples run_i low
`timescale 1ns/10ps
module osc_stab_timer #(
   parameter int CYCLES = 500
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Oscillator state
   input wire logic run_i,
   output logic stable_o
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_stable;

   always_comb begin
      next_count = count;
      next_stable = stable_o;
      if (!run_i) begin
         next_count = '0;
         next_stable = 1'b0;
      end else if (!stable_o) begin
         if (count == LAST) begin
            next_stable = 1'b1;
         end else begin
            next_count = count + W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         stable_o <= 1'b0;
      end else begin
         count <= next_count;
         stable_o <= next_stable;
      end
   end
endmodule // osc_stab_timer

// [design/src_switch.sv]
// Purpose: Follows a clock source request through the glitch-free mux delay
// Assumes: Request held stable while a switch is in progress
// Notes: cur_o is the source the mux really uses
`timescale 1ns/10ps
module src_switch #(
   parameter int CYCLES = 4
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Source request and applied source
   input wire logic req_i,
   output logic cur_o
);
   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES - 1);

   logic [W-1:0] count;
   logic [W-1:0] next_count;
   logic next_cur;

   always_comb begin
      next_count = '0;
      next_cur = cur_o;
      if (req_i != cur_o) begin
         if (count == LAST) begin
            next_cur = req_i;
         end else begin
            next_count = count + W'(1);
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         cur_o <= 1'b0;
      end else begin
         count <= next_count;
         cur_o <= next_cur;
      end
   end
endmodule // src_switch

// [design/osc_stop_start_clock_select.sv]
// Purpose: Oscillator start/stop, clock source selection and CPU clock status
// Assumes: Classic Wishbone slave, stop and wake pulses from same-clock logic
// Notes: Prohibited divider codes are stored but never reach the divider
//
// Behaviour
// - Status flags report CPU source: internal, high-speed, or subsystem.
// - Main oscillator stop bit halts X1 or blocks external main input.
// - Clearing internal stop bit runs the internal high-speed oscillator.
// - Stable flag rises after settling; software may poll or skip it.
// - After reset internal oscillator runs and clocks the CPU.
// - Source selectors pick main and peripheral clocks per the table.
// - CPU runs from main clock divided by 1,2,4,8,16; default 2.
// - STOP instruction enters STOP mode and halts the internal oscillator.
// - Setting internal stop bit halts the internal high-speed oscillator.
// - Subsystem pins are ports after reset and while unused.
// - Subsystem pins enter XT1 mode by select, or forced by force bit.
// - Subsystem external mode: first pin port, second pin takes clock.
// - Selector bits sit at documented positions in their registers.
`timescale 1ns/10ps
module osc_stop_start_clock_select #(
   parameter int STAB_CYCLES = clk_ctrl_pkg::INT_STAB_CYCLES,
   parameter int MUX_CYCLES = clk_ctrl_pkg::SWITCH_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // Standby control
   input wire logic stop_exec_i,
   input wire logic wake_i,
   output logic stop_mode_o,
   // Oscillator enables and pin modes
   output logic x1_osc_en_o,
   output logic ext_main_en_o,
   output logic int_hs_en_o,
   output logic [1:0] main_pin_mode_o,
   output logic [1:0] sub_pin_mode_o,
   // Clock selection
   output logic main_clk_hs_o,
   output logic periph_clk_hs_o,
   output logic cpu_clk_sub_o,
   output logic [2:0] cpu_div_o,
   output logic [2:0] wake_stab_sel_o
);

   // Software-written control state
   logic [2:0] cpu_div;
   logic cpu_src_select;
   logic sub_osc_force;
   logic main_src_select;
   logic hs_src_select;
   logic main_osc_stop;
   logic int_hs_osc_stop;
   logic sub_osc_select;
   logic sub_ext_clk_sel;
   logic main_osc_select;
   logic main_ext_clk_sel;
   logic [2:0] wake_stab_time_sel;
   logic [2:0] next_cpu_div;
   logic next_cpu_src_select;
   logic next_sub_osc_force;
   logic next_main_src_select;
   logic next_hs_src_select;
   logic next_main_osc_stop;
   logic next_int_hs_osc_stop;
   logic next_sub_osc_select;
   logic next_sub_ext_clk_sel;
   logic next_main_osc_select;
   logic next_main_ext_clk_sel;
   logic [2:0] next_wake_stab_time_sel;
   // Bus answer
   logic [31:0] next_dat;
   logic next_ack;
   logic bus_req;
   logic bus_wr;
   logic [7:0] rd_byte;
   // Power state
   clk_ctrl_pkg::pwr_state_t pwr;
   clk_ctrl_pkg::pwr_state_t next_pwr;
   // Derived clocking
   logic int_hs_run;
   logic int_hs_stable;
   logic main_src_status;
   logic sub_clock_active;
   logic periph_hs_cur;
   logic main_hs_req;
   clk_ctrl_pkg::pin_mode_t main_mode;
   clk_ctrl_pkg::pin_mode_t sub_mode;
   // Output next values
   logic next_x1_en;
   logic next_ext_main_en;
   logic next_int_hs_en;
   logic [2:0] next_cpu_div_o;

   assign bus_req = cyc_i && stb_i && !ack_o;
   assign bus_wr = bus_req && we_i && sel_i[0];

   always_comb begin
      next_cpu_div = cpu_div;
      next_cpu_src_select = cpu_src_select;
      next_sub_osc_force = sub_osc_force;
      next_main_src_select = main_src_select;
      next_hs_src_select = hs_src_select;
      next_main_osc_stop = main_osc_stop;
      next_int_hs_osc_stop = int_hs_osc_stop;
      next_sub_osc_select = sub_osc_select;
      next_sub_ext_clk_sel = sub_ext_clk_sel;
      next_main_osc_select = main_osc_select;
      next_main_ext_clk_sel = main_ext_clk_sel;
      next_wake_stab_time_sel = wake_stab_time_sel;
      if (bus_wr) begin
         unique case (adr_i)
            clk_ctrl_pkg::OFF_PROC: begin
               next_cpu_div = dat_i[clk_ctrl_pkg::PROC_DIV_LSB +: 3];
               next_cpu_src_select = dat_i[clk_ctrl_pkg::PROC_CPU_SRC];
               next_sub_osc_force = dat_i[clk_ctrl_pkg::PROC_SUB_FORCE];
            end
            clk_ctrl_pkg::OFF_MODE: begin
               next_main_src_select = dat_i[clk_ctrl_pkg::MODE_MAIN_SRC];
               next_hs_src_select = dat_i[clk_ctrl_pkg::MODE_HS_SRC];
            end
            clk_ctrl_pkg::OFF_MOSC: next_main_osc_stop = dat_i[clk_ctrl_pkg::MOSC_STOP];
            clk_ctrl_pkg::OFF_IOSC: next_int_hs_osc_stop = dat_i[clk_ctrl_pkg::IOSC_STOP];
            clk_ctrl_pkg::OFF_PIN: begin
               next_sub_osc_select = dat_i[clk_ctrl_pkg::PIN_SUB_SEL];
               next_sub_ext_clk_sel = dat_i[clk_ctrl_pkg::PIN_SUB_EXT];
               next_main_osc_select = dat_i[clk_ctrl_pkg::PIN_MAIN_SEL];
               next_main_ext_clk_sel = dat_i[clk_ctrl_pkg::PIN_MAIN_EXT];
            end
            clk_ctrl_pkg::OFF_WAKE: next_wake_stab_time_sel = dat_i[clk_ctrl_pkg::WAKE_LSB +: 3];
            default: begin
               // Unmapped writes are acknowledged and dropped
            end
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cpu_div <= clk_ctrl_pkg::RST_CPU_DIV;
         cpu_src_select <= 1'b0;
         sub_osc_force <= 1'b0;
         main_src_select <= 1'b0;
         hs_src_select <= 1'b0;
         main_osc_stop <= clk_ctrl_pkg::RST_MAIN_OSC_STOP;
         int_hs_osc_stop <= 1'b0;
         sub_osc_select <= 1'b0;
         sub_ext_clk_sel <= 1'b0;
         main_osc_select <= 1'b0;
         main_ext_clk_sel <= 1'b0;
         wake_stab_time_sel <= clk_ctrl_pkg::RST_WAKE_SEL;
      end else begin
         cpu_div <= next_cpu_div;
         cpu_src_select <= next_cpu_src_select;
         sub_osc_force <= next_sub_osc_force;
         main_src_select <= next_main_src_select;
         hs_src_select <= next_hs_src_select;
         main_osc_stop <= next_main_osc_stop;
         int_hs_osc_stop <= next_int_hs_osc_stop;
         sub_osc_select <= next_sub_osc_select;
         sub_ext_clk_sel <= next_sub_ext_clk_sel;
         main_osc_select <= next_main_osc_select;
         main_ext_clk_sel <= next_main_ext_clk_sel;
         wake_stab_time_sel <= next_wake_stab_time_sel;
      end
   end

   always_comb begin
      next_pwr = pwr;
      unique case (pwr)
         clk_ctrl_pkg::PWR_RUN: next_pwr = stop_exec_i ? clk_ctrl_pkg::PWR_STOP : pwr;
         clk_ctrl_pkg::PWR_STOP: next_pwr = wake_i ? clk_ctrl_pkg::PWR_RUN : pwr;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pwr <= clk_ctrl_pkg::PWR_RUN;
      end else begin
         pwr <= next_pwr;
      end
   end
   // clear to run, set to halt
   assign int_hs_run = !int_hs_osc_stop && (pwr == clk_ctrl_pkg::PWR_RUN);
   osc_stab_timer #(
      .CYCLES(STAB_CYCLES)
   ) u_int_stab (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(int_hs_run),
      .stable_o(int_hs_stable)
   );
   // forced or selected XT1, external subsystem input
   assign sub_mode = clk_ctrl_pkg::pin_mode(sub_osc_force, sub_ext_clk_sel, sub_osc_select);
   assign main_mode = clk_ctrl_pkg::pin_mode(1'b0, main_ext_clk_sel, main_osc_select);
   // main follows high-speed only with both selectors set
   assign main_hs_req = hs_src_select && main_src_select;
   src_switch #(
      .CYCLES(MUX_CYCLES)
   ) u_main_sw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(main_hs_req),
      .cur_o(main_src_status)
   );
   src_switch #(
      .CYCLES(MUX_CYCLES)
   ) u_periph_sw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(hs_src_select),
      .cur_o(periph_hs_cur)
   );
   src_switch #(
      .CYCLES(MUX_CYCLES)
   ) u_cpu_sw (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .req_i(cpu_src_select),
      .cur_o(sub_clock_active)
   );

   // Oscillator enables and divider feed
   always_comb begin
      // stop bit halts X1 or blocks input
      next_x1_en = (main_mode == clk_ctrl_pkg::PIN_OSC) && !main_osc_stop &&
                   (pwr == clk_ctrl_pkg::PWR_RUN);
      next_ext_main_en = (main_mode == clk_ctrl_pkg::PIN_EXT) && !main_osc_stop &&
                         (pwr == clk_ctrl_pkg::PWR_RUN);
      next_int_hs_en = int_hs_run;
      // prohibited codes keep the last legal ratio
      next_cpu_div_o = (cpu_div <= clk_ctrl_pkg::DIV_MAX_CODE) ? cpu_div : cpu_div_o;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         x1_osc_en_o <= 1'b0;
         ext_main_en_o <= 1'b0;
         int_hs_en_o <= 1'b0;
         main_pin_mode_o <= clk_ctrl_pkg::PIN_PORT;
         sub_pin_mode_o <= clk_ctrl_pkg::PIN_PORT;
         main_clk_hs_o <= 1'b0;
         periph_clk_hs_o <= 1'b0;
         cpu_clk_sub_o <= 1'b0;
         cpu_div_o <= clk_ctrl_pkg::RST_CPU_DIV;
         wake_stab_sel_o <= clk_ctrl_pkg::RST_WAKE_SEL;
         stop_mode_o <= 1'b0;
      end else begin
         x1_osc_en_o <= next_x1_en;
         ext_main_en_o <= next_ext_main_en;
         int_hs_en_o <= next_int_hs_en;
         main_pin_mode_o <= main_mode;
         sub_pin_mode_o <= sub_mode;
         main_clk_hs_o <= main_src_status;
         periph_clk_hs_o <= periph_hs_cur;
         cpu_clk_sub_o <= sub_clock_active;
         cpu_div_o <= next_cpu_div_o;
         wake_stab_sel_o <= wake_stab_time_sel;
         stop_mode_o <= (next_pwr == clk_ctrl_pkg::PWR_STOP);
      end
   end

   // Register read-back
   always_comb begin
      rd_byte = 8'h00;
      unique case (adr_i)
         clk_ctrl_pkg::OFF_PROC: begin
            rd_byte[clk_ctrl_pkg::PROC_DIV_LSB +: 3] = cpu_div;
            rd_byte[clk_ctrl_pkg::PROC_CPU_SRC] = cpu_src_select;
            rd_byte[clk_ctrl_pkg::PROC_SUB_ACT] = sub_clock_active;
            rd_byte[clk_ctrl_pkg::PROC_SUB_FORCE] = sub_osc_force;
         end
         clk_ctrl_pkg::OFF_MODE: begin
            rd_byte[clk_ctrl_pkg::MODE_MAIN_SRC] = main_src_select;
            rd_byte[clk_ctrl_pkg::MODE_MAIN_STS] = main_src_status;
            rd_byte[clk_ctrl_pkg::MODE_HS_SRC] = hs_src_select;
         end
         clk_ctrl_pkg::OFF_MOSC: rd_byte[clk_ctrl_pkg::MOSC_STOP] = main_osc_stop;
         clk_ctrl_pkg::OFF_IOSC: begin
            rd_byte[clk_ctrl_pkg::IOSC_STOP] = int_hs_osc_stop;
            rd_byte[clk_ctrl_pkg::IOSC_STABLE] = int_hs_stable;
         end
         clk_ctrl_pkg::OFF_PIN: begin
            rd_byte[clk_ctrl_pkg::PIN_SUB_SEL] = sub_osc_select;
            rd_byte[clk_ctrl_pkg::PIN_SUB_EXT] = sub_ext_clk_sel;
            rd_byte[clk_ctrl_pkg::PIN_MAIN_SEL] = main_osc_select;
            rd_byte[clk_ctrl_pkg::PIN_MAIN_EXT] = main_ext_clk_sel;
         end
         clk_ctrl_pkg::OFF_WAKE: rd_byte[clk_ctrl_pkg::WAKE_LSB +: 3] = wake_stab_time_sel;
         default: rd_byte = 8'h00;
      endcase
      next_ack = bus_req;
      next_dat = 32'h00000000;
      if (bus_req && !we_i) begin
         next_dat = {24'h000000, rd_byte};
      end
   end

   // Answer one cycle after the request; reads zero outside a read ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h00000000;
      end else begin
         ack_o <= next_ack;
         dat_o <= next_dat;
      end
   end

endmodule // osc_stop_start_clock_select

// [test/osc_ctrl_sva.sv]
// Purpose: Port-level checks of the clock control block
// Assumes: One clock, synchronous active-high reset
// Notes: Source lag follows the mux delay parameter
`timescale 1ns/10ps
module osc_ctrl_sva #(
   parameter int STAB_CYCLES = clk_ctrl_pkg::INT_STAB_CYCLES,
   parameter int MUX_CYCLES = clk_ctrl_pkg::SWITCH_CYCLES
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Bus
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [7:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // Standby
   input wire logic stop_exec_i,
   input wire logic wake_i,
   input wire logic stop_mode_o,
   // Oscillators and selection
   input wire logic x1_osc_en_o,
   input wire logic ext_main_en_o,
   input wire logic int_hs_en_o,
   input wire logic [1:0] main_pin_mode_o,
   input wire logic [1:0] sub_pin_mode_o,
   input wire logic main_clk_hs_o,
   input wire logic periph_clk_hs_o,
   input wire logic cpu_clk_sub_o,
   input wire logic [2:0] cpu_div_o,
   input wire logic [2:0] wake_stab_sel_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // Mux delay plus the status register stage
   localparam int LAG = MUX_CYCLES + 1;
   logic wr;
   assign wr = cyc_i && stb_i && we_i && !ack_o && sel_i[0];

   sequence s_late_rise(sig);
      ##LAG !sig ##1 sig;
   endsequence

   a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("no ack one cycle after request");
   a_ack_single: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
      else $error("read data outside ack");
   a_boot_int: assert property (
      $fell(rst_i) |=> int_hs_en_o && !cpu_clk_sub_o && sub_pin_mode_o == 2'b00)
      else $error("wrong state after reset");
   a_div_apply: assert property (
      wr && adr_i == 8'h00 && dat_i[2:0] <= 3'h4 |=> ##1 cpu_div_o == $past(dat_i[2:0], 2))
      else $error("divider code not applied");
   a_div_hold: assert property (
      wr && adr_i == 8'h00 && dat_i[2:0] > 3'h4 |=> ##1 cpu_div_o == $past(cpu_div_o, 2))
      else $error("prohibited divider code applied");
   a_periph_late: assert property (
      wr && adr_i == 8'h04 && dat_i[2] && !periph_clk_hs_o |-> s_late_rise(periph_clk_hs_o))
      else $error("peripheral source switch timing");
   a_cpu_late: assert property (
      wr && adr_i == 8'h00 && dat_i[4] && !cpu_clk_sub_o |-> s_late_rise(cpu_clk_sub_o))
      else $error("cpu source switch timing");
   a_main_pair: assert property (main_clk_hs_o |-> periph_clk_hs_o)
      else $error("main on high-speed without peripheral");
   a_int_halt: assert property (wr && adr_i == 8'h0c && dat_i[0] |=> ##1 !int_hs_en_o)
      else $error("internal oscillator not halted");
   a_int_run: assert property (
      wr && adr_i == 8'h0c && !dat_i[0] && !stop_mode_o |=> ##1 int_hs_en_o)
      else $error("internal oscillator not started");
   a_x1_halt: assert property (
      wr && adr_i == 8'h08 && dat_i[7] |=> ##1 !x1_osc_en_o && !ext_main_en_o)
      else $error("main oscillator not halted");
   a_stop_halt: assert property (
      stop_exec_i && !stop_mode_o |=> ##1 stop_mode_o && !int_hs_en_o)
      else $error("stop mode keeps oscillator");

   // Edges the internal enable has stood high, capped at the settling count
   int run_cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i || !int_hs_en_o) begin
         run_cnt <= 0;
      end else if (run_cnt < STAB_CYCLES) begin
         run_cnt <= run_cnt + 1;
      end
   end

   a_stable_time: assert property (
      ack_o && !we_i && adr_i == 8'h0c |-> dat_o[1] == (run_cnt >= STAB_CYCLES))
      else $error("stable flag timing");
endmodule // osc_ctrl_sva

// [test/test_osc_stop_start_clock_select.sv]
// Purpose: Self-checking bench for the clock control block
// Assumes: Wishbone master tasks, shortened settle and mux counts
// Notes: Fixed waits cover the note's latencies with margin
`timescale 1ns/10ps
module test_osc_stop_start_clock_select;
   localparam int STAB = 4;
   localparam int MUX = 1;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [7:0] adr_i = 8'h00;
   logic [3:0] sel_i = 4'h0;
   logic [31:0] dat_i = 32'h0;
   logic stop_exec_i = 1'b0;
   logic wake_i = 1'b0;
   logic [31:0] dat_o;
   logic ack_o, stop_mode_o, x1_osc_en_o, ext_main_en_o, int_hs_en_o;
   logic main_clk_hs_o, periph_clk_hs_o, cpu_clk_sub_o;
   logic [1:0] main_pin_mode_o, sub_pin_mode_o;
   logic [2:0] cpu_div_o, wake_stab_sel_o;
   int mismatches = 0;
   int comparisons = 0;
   logic [7:0] rst_val [6] = '{8'h01, 8'h00, 8'h80, 8'h02, 8'h00, 8'h00};
   logic [7:0] mode_wr [3] = '{8'h01, 8'h04, 8'h05};
   logic [7:0] mode_rd [3] = '{8'h01, 8'h04, 8'h07};

   osc_stop_start_clock_select #(.STAB_CYCLES(STAB), .MUX_CYCLES(MUX))
      osc_stop_start_clock_select_i (.*);

   initial begin
      forever #2 clk_i = ~clk_i;
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] q);
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      logic [31:0] q;
      wb(1'b0, a, 8'h00, q);
      chk(q, {24'h0, exp});
   endtask

   // Long enough for mux lag and oscillator settling
   task automatic settle();
      repeat (STAB + MUX + 6) @(posedge clk_i);
   endtask

   task complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_i);
      mismatches++;
      complete_run();
   end

   initial begin
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      settle();
      chk(32'({int_hs_en_o, cpu_clk_sub_o, sub_pin_mode_o}), 32'h8);
      for (int i = 0; i < 6; i++) begin
         rd(8'(4 * i), rst_val[i]);
      end
      rd(8'h18, 8'h00);
      for (int i = 0; i < 5; i++) begin
         wr(8'h00, 8'(i));
         settle();
         chk(32'(cpu_div_o), 32'(i));
      end
      wr(8'h00, 8'h05);
      rd(8'h00, 8'h05);
      chk(32'(cpu_div_o), 32'h4);
      wr(8'h00, 8'h01);
      for (int i = 0; i < 3; i++) begin
         wr(8'h04, mode_wr[i]);
         settle();
         chk(32'({main_clk_hs_o, periph_clk_hs_o}), 32'({mode_rd[i][1], mode_rd[i][2]}));
         rd(8'h04, mode_rd[i]);
      end
      // Main now runs from the high-speed clock
      wr(8'h0c, 8'h01);
      settle();
      chk(32'(int_hs_en_o), 32'h0);
      rd(8'h0c, 8'h01);
      wr(8'h0c, 8'h00);
      rd(8'h0c, 8'h00);
      settle();
      chk(32'(int_hs_en_o), 32'h1);
      rd(8'h0c, 8'h02);
      wr(8'h04, 8'h00);
      for (int j = 0; j < 2; j++) begin
         wr(8'h10, j ? 8'hc0 : 8'h40);
         wr(8'h08, 8'h00);
         settle();
         chk(32'({main_pin_mode_o, x1_osc_en_o, ext_main_en_o}), j ? 32'h9 : 32'h6);
         wr(8'h08, 8'h80);
         settle();
         chk(32'({x1_osc_en_o, ext_main_en_o}), 32'h0);
      end
      wr(8'h10, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'h00, {1'b0, i[2], 6'h01});
         wr(8'h10, {2'b00, i[1:0], 4'h0});
         settle();
         chk(32'(sub_pin_mode_o), i[2] ? 32'h1 : !i[0] ? 32'h0 : i[1] ? 32'h2 : 32'h1);
      end
      settle();
      wr(8'h00, 8'h51);
      settle();
      chk(32'(cpu_clk_sub_o), 32'h1);
      rd(8'h00, 8'h71);
      wr(8'h00, 8'h01);
      wr(8'h14, 8'h03);
      settle();
      chk(32'(wake_stab_sel_o), 32'h3);
      stop_exec_i <= 1'b1;
      @(posedge clk_i);
      stop_exec_i <= 1'b0;
      settle();
      chk(32'({stop_mode_o, int_hs_en_o, x1_osc_en_o}), 32'h4);
      wake_i <= 1'b1;
      @(posedge clk_i);
      wake_i <= 1'b0;
      settle();
      chk(32'({stop_mode_o, int_hs_en_o}), 32'h1);
      complete_run();
   end
endmodule // test_osc_stop_start_clock_select

bind osc_stop_start_clock_select osc_ctrl_sva #(.STAB_CYCLES(STAB_CYCLES),
   .MUX_CYCLES(MUX_CYCLES)) osc_ctrl_sva_i (.*);
